/* design/ext_bus_pkg.sv */
// Purpose: Shared constants and carriers for the external bus address decoder
// Assumes: 32-bit internal address, eight external chip-select spaces
// Notes: Every map boundary, field position, reset value and count lives here
package ext_bus_pkg;
   localparam int ADDR_W = 32;
   localparam int EXT_ADDR_W = 22;
   localparam int NUM_SPACES = 8;
   localparam int NUM_LANES = 4;
   localparam int CTRL_W = 16;
   localparam int NUM_CTRL = 5;
   // Space-type field and select field
   localparam int TYPE_MSB = 31;
   localparam int TYPE_LSB = 24;
   localparam int SEL_MSB = 23;
   localparam int SEL_LSB = 22;
   localparam int PORT_MSB = 21;
   localparam int PORT_LSB = 18;
   localparam logic [7:0] TYPE_EXT_LO = 8'h00;
   localparam logic [7:0] TYPE_EXT_HI = 8'h01;
   // Map boundaries
   localparam logic [31:0] ROM_END = 32'h0003FFFF;
   localparam logic [31:0] CS0_ROM_BASE = 32'h00200000;
   localparam logic [31:0] GAP_BASE = 32'h01000000;
   localparam logic [31:0] CS4_ROM_BASE = 32'h01200000;
   localparam logic [31:0] PERI_BASE = 32'hFFFF8000;
   localparam logic [31:0] PERI_END = 32'hFFFFBFFF;
   localparam logic [31:0] RAM_BASE = 32'hFFFFE000;
   // Control register indices, field positions and reset values
   localparam int IDX_BUS1 = 0;
   localparam int IDX_BUS2 = 1;
   localparam int IDX_WAIT1 = 2;
   localparam int IDX_WAIT2 = 3;
   localparam int IDX_RAMEMU = 4;
   localparam int LG_POS = 4;
   localparam int SZ_POS = 0;
   localparam logic [15:0] BUS1_RST = 16'h600F;
   localparam logic [15:0] BUS2_RST = 16'h0000;
   localparam logic [15:0] WAIT1_RST = 16'hFFFF;
   localparam logic [15:0] WAIT2_RST = 16'h0000;
   localparam logic [15:0] RAMEMU_RST = 16'h0000;
   localparam int WAIT_FLD_W = 4;
   localparam int WAIT_PAIR_W = 2;
   // Bus width codes
   localparam logic [1:0] WIDTH_8 = 2'h0;
   localparam logic [1:0] WIDTH_16 = 2'h1;
   localparam logic [1:0] WIDTH_32 = 2'h2;
   localparam logic [1:0] WIDTH_NONE = 2'h3;

   typedef enum logic [2:0] {
      REG_ROM = 3'h0, REG_EXT = 3'h1, REG_PERI = 3'h2, REG_RAM = 3'h3, REG_RSVD = 3'h4
   } region_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic write;
      logic [NUM_LANES-1:0] lanes;
   } access_req_t;

   typedef struct packed {
      region_t region;
      logic [NUM_SPACES-1:0] select;
      logic [2:0] space;
      logic [1:0] width;
   } decode_t;

   typedef struct packed {
      logic rom_enabled;
      logic large_pkg;
      logic mode_wide;
      logic upper_spaces;
   } strap_t;
endpackage : ext_bus_pkg

/* design/space_decoder.sv */
// Purpose: Combinational decode of an internal address into region and space
// Assumes: Straps and control words are stable while an access is decoded
// Notes: Pure logic; the caller registers the result
`timescale 1ns/1ns
module space_decoder
   import ext_bus_pkg::*;
(
   input wire logic [ADDR_W-1:0] addr,
   input wire strap_t straps,
   input wire logic [CTRL_W-1:0] bus_ctrl_one,
   output decode_t dec
);
   logic [7:0] type_f;
   logic [2:0] sp;
   logic ext_hit;
   logic lg;
   logic sz;

   // Region and select decode
   always_comb begin
      type_f = addr[TYPE_MSB:TYPE_LSB];
      sp = {type_f[0], addr[SEL_MSB:SEL_LSB]};
      ext_hit = (type_f == TYPE_EXT_LO) || (type_f == TYPE_EXT_HI);
      dec.space = sp;
      dec.select = '1;
      dec.width = WIDTH_NONE;
      dec.region = REG_RSVD;
      if (straps.rom_enabled && addr <= ROM_END) begin
         dec.region = REG_ROM;
      end else if (straps.rom_enabled && ext_hit && addr < CS0_ROM_BASE) begin
         dec.region = REG_RSVD;
      end else if (straps.rom_enabled && addr >= GAP_BASE && addr < CS4_ROM_BASE) begin
         dec.region = REG_RSVD;
      end else if (ext_hit && (sp < 3'h4 || straps.upper_spaces)) begin
         dec.region = REG_EXT;
      end else if (addr >= PERI_BASE && addr <= PERI_END) begin
         dec.region = REG_PERI;
      end else if (addr >= RAM_BASE) begin
         dec.region = REG_RAM;
      end
      if (dec.region == REG_EXT) begin
         dec.select[sp] = 1'b0;
      end
      // On-chip ROM and RAM are one-state 32-bit ports
      if (dec.region == REG_ROM || dec.region == REG_RAM) begin
         dec.width = WIDTH_32;
      end
      lg = bus_ctrl_one[LG_POS + int'(sp[1:0])];
      sz = bus_ctrl_one[SZ_POS + int'(sp[1:0])];
      if (dec.region == REG_EXT) begin
         if (!straps.rom_enabled && sp[1:0] == 2'h0) begin
            // Strap sets width of spaces 0 and 4 when ROM is off
            if (straps.large_pkg) begin
               dec.width = straps.mode_wide ? WIDTH_32 : WIDTH_16;
            end else begin
               dec.width = straps.mode_wide ? WIDTH_16 : WIDTH_8;
            end
         end else if (lg) begin
            dec.width = WIDTH_32;
         end else begin
            dec.width = sz ? WIDTH_16 : WIDTH_8;
         end
      end
   end
endmodule : space_decoder

/* design/external_bus_address_decoder.sv */
// Purpose: Address decode and external pin sequencing for SRAM/ROM spaces
// Assumes: One access request at a time, held until acc_done
// Notes: Control registers are plain ports; outputs are all registered
`timescale 1ns/1ns

module external_bus_address_decoder
   import ext_bus_pkg::*;
#(
   parameter int WAIT_MAX = 15
)
(
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic clk_en,
   input wire strap_t straps,
   input wire access_req_t req,
   input wire logic req_valid,
   output logic acc_done,
   output logic acc_error,
   output logic [2:0] acc_region,
   output logic [1:0] acc_width,
   input wire logic ctrl_we,
   input wire logic [2:0] ctrl_idx,
   input wire logic [CTRL_W-1:0] ctrl_wdata,
   output logic [CTRL_W-1:0] ctrl_rdata,
   input wire logic addr_hi_enable,
   output logic [EXT_ADDR_W-1:0] ext_addr,
   output logic [3:0] ext_addr_hi_oe,
   output logic [NUM_SPACES-1:0] space_select_n,
   output logic read_strobe_n,
   output logic write_lane3_n,
   output logic write_lane2_n,
   output logic write_lane1_n,
   output logic write_lane0_n,
   input wire logic wait_req_n,
   input wire logic ext_master_request_n,
   output logic bus_grant_n
);
   initial begin
      if (WAIT_MAX < 1 || WAIT_MAX > 15) begin
         $error("WAIT_MAX must lie in 1..15");
      end
   end

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00, ST_SETUP = 2'b01, ST_STROBE = 2'b11, ST_FINISH = 2'b10
   } bus_state_t;

   bus_state_t state_r;
   logic [CTRL_W-1:0] ctrl_r [NUM_CTRL];
   logic [2:0] wait_sync_r;
   logic [2:0] ext_master_request_sync_r;
   logic wait_act;
   logic ext_master_request_act;
   logic [3:0] wait_cnt_r;
   logic [3:0] wait_load;
   logic addr_hi_en_r;
   decode_t dec;
   decode_t dec_r;
   logic req_write_r;
   logic [NUM_LANES-1:0] req_lanes_r;

   space_decoder u_decode (
      .addr(req.addr),
      .straps(straps),
      .bus_ctrl_one(ctrl_r[IDX_BUS1]),
      .dec(dec)
   );

   // Control registers: bus_ctrl_one, bus_ctrl_two, wait_ctrl_one/two, ram_emulation_ctrl
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r[IDX_BUS1] <= BUS1_RST;
         ctrl_r[IDX_BUS2] <= BUS2_RST;
         ctrl_r[IDX_WAIT1] <= WAIT1_RST;
         ctrl_r[IDX_WAIT2] <= WAIT2_RST;
         ctrl_r[IDX_RAMEMU] <= RAMEMU_RST;
      end else if (clk_en && ctrl_we && int'(ctrl_idx) < NUM_CTRL) begin
         ctrl_r[ctrl_idx] <= ctrl_wdata;
      end
   end

   // Readback; unknown index reads zero
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_rdata <= '0;
      end else if (clk_en) begin
         ctrl_rdata <= (int'(ctrl_idx) < NUM_CTRL) ? ctrl_r[ctrl_idx] : '0;
      end
   end

   // Three-stage synchronisers for pin inputs; first stage feeds only the second
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wait_sync_r <= 3'h7;
         ext_master_request_sync_r <= 3'h7;
      end else if (clk_en) begin
         wait_sync_r <= {wait_sync_r[1:0], wait_req_n};
         ext_master_request_sync_r <= {ext_master_request_sync_r[1:0], ext_master_request_n};
      end
   end

   // A level change counts only when stages two and three agree
   logic wait_lvl_r;
   logic ext_master_request_lvl_r;
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         wait_lvl_r <= 1'b0;
         ext_master_request_lvl_r <= 1'b0;
      end else if (clk_en) begin
         if (wait_sync_r[1] == wait_sync_r[2]) wait_lvl_r <= !wait_sync_r[2];
         if (ext_master_request_sync_r[1] == ext_master_request_sync_r[2]) ext_master_request_lvl_r <= !ext_master_request_sync_r[2];
      end
   end
   assign wait_act = wait_lvl_r;
   assign ext_master_request_act = ext_master_request_lvl_r;

   // Per-space wait count: four bits per space, wait_ctrl_one spaces 0-3, the second wait register spaces 4-7
   always_comb begin
      wait_load = ctrl_r[IDX_WAIT1][WAIT_FLD_W*int'(dec.space[1:0]) +: WAIT_FLD_W];
      if (dec.space[2]) begin
         wait_load = ctrl_r[IDX_WAIT2][WAIT_FLD_W*int'(dec.space[1:0]) +: WAIT_FLD_W];
      end
      if (int'(wait_load) > WAIT_MAX) begin
         wait_load = 4'(WAIT_MAX);
      end
   end

   // Upper address pins stay port pins until software enables them
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         addr_hi_en_r <= 1'b0;
         ext_addr_hi_oe <= 4'h0;
      end else if (clk_en) begin
         addr_hi_en_r <= addr_hi_enable;
         ext_addr_hi_oe <= {4{addr_hi_enable}};
      end
   end

   // Access sequencer; grant only taken between accesses so no cycle is torn
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         wait_cnt_r <= 4'h0;
         dec_r <= '{region: REG_RSVD, select: '1, space: 3'h0, width: WIDTH_NONE};
         req_write_r <= 1'b0;
         req_lanes_r <= '0;
         ext_addr <= '0;
         space_select_n <= '1;
         read_strobe_n <= 1'b1;
         {write_lane3_n, write_lane2_n, write_lane1_n, write_lane0_n} <= 4'hF;
         acc_done <= 1'b0;
         acc_error <= 1'b0;
         acc_region <= 3'h0;
         acc_width <= WIDTH_NONE;
         bus_grant_n <= 1'b1;
      end else if (clk_en) begin
         acc_done <= 1'b0;
         acc_error <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (ext_master_request_act) begin
                  bus_grant_n <= 1'b0;
               end else begin
                  bus_grant_n <= 1'b1;
                  if (req_valid && bus_grant_n) begin
                     dec_r <= dec;
                     req_write_r <= req.write;
                     req_lanes_r <= req.lanes;
                     acc_region <= 3'(dec.region);
                     acc_width <= dec.width;
                     if (dec.region == REG_EXT) begin
                        // Top byte never leaves the chip
                        ext_addr <= req.addr[EXT_ADDR_W-1:0];
                        if (!addr_hi_en_r) begin
                           ext_addr[PORT_MSB:PORT_LSB] <= 4'h0;
                        end
                        space_select_n <= dec.select;
                        wait_cnt_r <= wait_load;
                        state_r <= ST_SETUP;
                     end else begin
                        // On-chip or reserved: no external select
                        space_select_n <= '1;
                        acc_done <= 1'b1;
                        acc_error <= (dec.region == REG_RSVD);
                     end
                  end
               end
            end
            ST_SETUP: begin
               read_strobe_n <= req_write_r;
               {write_lane3_n, write_lane2_n, write_lane1_n, write_lane0_n} <=
                  req_write_r ? ~req_lanes_r : 4'hF;
               state_r <= ST_STROBE;
            end
            ST_STROBE: begin
               if (wait_cnt_r != 4'h0) begin
                  wait_cnt_r <= wait_cnt_r - 4'h1;
               end else if (!wait_act) begin
                  state_r <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               read_strobe_n <= 1'b1;
               {write_lane3_n, write_lane2_n, write_lane1_n, write_lane0_n} <= 4'hF;
               space_select_n <= '1;
               acc_done <= 1'b1;
               state_r <= ST_IDLE;
            end
            default: begin
               state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Assertion helpers
   logic ext_cycle;
   logic take_ext;
   logic [PORT_LSB-1:0] low_addr;
   assign ext_cycle = (state_r == ST_STROBE);
   // An external access is taken at this edge
   assign take_ext = (state_r == ST_IDLE) && clk_en && req_valid && bus_grant_n && !ext_master_request_act
      && (dec.region == REG_EXT);
   assign low_addr = req.addr[PORT_LSB-1:0];

   // Selects: at most one low, and the decoded one while strobing
   a_select_onehot: assert property (@(posedge sys_clk) disable iff (!resetn)
      $countones(~space_select_n) <= 1)
      else $error("More than one space select active");

   a_select_space: assert property (@(posedge sys_clk) disable iff (!resetn)
      ext_cycle |-> !space_select_n[dec_r.space] && $countones(~space_select_n) == 1)
      else $error("Strobe phase without its space select");

   a_no_select_onchip: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_r == ST_IDLE && clk_en && req_valid && bus_grant_n && !ext_master_request_act
       && dec.region != REG_EXT) |=> space_select_n == '1)
      else $error("Select asserted for on-chip access");

   a_error_no_pins: assert property (@(posedge sys_clk) disable iff (!resetn)
      acc_error |-> acc_done && space_select_n == '1 && acc_region == 3'(REG_RSVD))
      else $error("Reserved access touched pins");

   // Address pins
   a_addr_low: assert property (@(posedge sys_clk) disable iff (!resetn)
      take_ext |=> ext_addr[PORT_LSB-1:0] == $past(low_addr))
      else $error("External address low bits wrong");

   a_addr_hi_port: assert property (@(posedge sys_clk) disable iff (!resetn)
      (take_ext && !addr_hi_en_r) |=> ext_addr[PORT_MSB:PORT_LSB] == 4'h0)
      else $error("Port pins carried address");

   a_port_pins_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
      !addr_hi_en_r |-> ext_addr[PORT_MSB:PORT_LSB] == 4'h0 || state_r != ST_STROBE)
      else $error("Upper address used while port");

   // Strobes
   a_read_strobe: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ext_cycle && !req_write_r) |-> !read_strobe_n && write_lane0_n && write_lane3_n)
      else $error("Read cycle without read strobe");

   a_write_lanes: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ext_cycle && req_write_r) |-> ({write_lane3_n, write_lane2_n, write_lane1_n,
       write_lane0_n} == ~req_lanes_r) && read_strobe_n)
      else $error("Write strobes do not match lanes");

   a_strobes_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_r == ST_IDLE) |-> read_strobe_n && ({write_lane3_n, write_lane2_n, write_lane1_n,
       write_lane0_n} == 4'hF))
      else $error("Strobe active between accesses");

   // Wait states, from software and from the pin
   a_wait_stretch: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ext_cycle && wait_act && clk_en) |=> state_r == ST_STROBE)
      else $error("Access ended while wait requested");

   a_wait_count: assert property (@(posedge sys_clk) disable iff (!resetn)
      (ext_cycle && wait_cnt_r != 4'h0 && clk_en) |=> state_r == ST_STROBE)
      else $error("Programmed wait states cut short");

   a_wait_load: assert property (@(posedge sys_clk) disable iff (!resetn)
      take_ext |=> wait_cnt_r == $past(wait_load))
      else $error("Wait count not loaded for space");

   // Bus hand-over to an external master
   a_grant_follows: assert property (@(posedge sys_clk) disable iff (!resetn)
      (state_r == ST_IDLE && ext_master_request_act && clk_en) |=> !bus_grant_n)
      else $error("Bus request not acknowledged");

   a_no_strobe_granted: assert property (@(posedge sys_clk) disable iff (!resetn)
      !bus_grant_n |-> read_strobe_n && space_select_n == '1)
      else $error("Strobe during external master ownership");

   a_grant_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
      !bus_grant_n |-> state_r == ST_IDLE)
      else $error("Bus granted during an access");

   // Map and widths
   a_rom_decode: assert property (@(posedge sys_clk) disable iff (!resetn)
      (straps.rom_enabled && req.addr <= ROM_END) |-> dec.region == REG_ROM)
      else $error("ROM range misdecoded");

   a_upper_reserved: assert property (@(posedge sys_clk) disable iff (!resetn)
      (!straps.upper_spaces && dec.space[2]) |-> dec.select[7:4] == 4'hF)
      else $error("Upper space selected on variant without it");

   a_onchip_width: assert property (@(posedge sys_clk) disable iff (!resetn)
      (acc_done && (acc_region == 3'(REG_ROM) || acc_region == 3'(REG_RAM)))
      |-> acc_width == WIDTH_32)
      else $error("On-chip memory width not 32 bits");

   a_strap_width: assert property (@(posedge sys_clk) disable iff (!resetn)
      (dec.region == REG_EXT && !straps.rom_enabled && dec.space[1:0] == 2'h0
       && !straps.large_pkg) |-> dec.width != WIDTH_32)
      else $error("Small package given 32-bit space");

   a_longword: assert property (@(posedge sys_clk) disable iff (!resetn)
      (dec.region == REG_EXT && straps.rom_enabled
       && ctrl_r[IDX_BUS1][LG_POS + int'(dec.space[1:0])]) |-> dec.width == WIDTH_32)
      else $error("Longword bit ignored");

   // Clock enable low holds every register
   a_freeze_hold: assert property (@(posedge sys_clk) disable iff (!resetn)
      !clk_en |=> $stable(state_r) && $stable(ctrl_rdata) && $stable(bus_grant_n))
      else $error("State moved while clock enable low");
endmodule : external_bus_address_decoder

/* tb/sram_partner.sv */
// Purpose: External memory stand-in that can stretch an access
// Assumes: Selects are active low and registered by the block
// Notes: Wait line idles high, as a pulled-up pin would
`timescale 1ns/1ns
module sram_partner (
   input wire logic sys_clk,
   input wire logic [7:0] space_select_n,
   input wire logic [7:0] stretch,
   output logic wait_req_n
);
   int left;
   logic sel_d;
   initial begin
      left = 0;
      sel_d = 1'b0;
      wait_req_n = 1'b1;
   end
   // Ask for wait from select onset; a slow device needs it early
   always @(negedge sys_clk) begin
      if (space_select_n != 8'hFF && !sel_d) begin
         left = int'(stretch);
      end
      sel_d = (space_select_n != 8'hFF);
      wait_req_n = (left == 0);
      if (left > 0) begin
         left--;
      end
   end
endmodule : sram_partner

/* tb/external_bus_address_decoder_tb.sv */
// Purpose: Self-checking bench for the external bus address decoder
// Assumes: One wait nibble per space, lowest space in lowest bits
// Notes: Cycle counts compared as differences, never as absolutes
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module external_bus_address_decoder_tb;
   import ext_bus_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic clk_en = 1'b1;
   strap_t straps = '{1'b1, 1'b1, 1'b1, 1'b1};
   access_req_t req = '0;
   logic req_valid = 1'b0;
   logic ctrl_we = 1'b0;
   logic [2:0] ctrl_idx = 3'h0;
   logic [15:0] ctrl_wdata = 16'h0000;
   logic addr_hi_enable = 1'b0;
   logic ext_master_request_n = 1'b1;
   logic [7:0] stretch = 8'h00;
   logic acc_done, acc_error, read_strobe_n, w3, w2, w1, w0, wait_req_n, bus_grant_n;
   logic [2:0] acc_region;
   logic [1:0] acc_width;
   logic [15:0] ctrl_rdata;
   logic [15:0] bc = BUS1_RST;
   logic [21:0] ext_addr;
   logic [3:0] hi_oe;
   logic [7:0] sel_n;
   int bad_count = 0;
   int cmp_count = 0;
   int c1, c2;
   logic [31:0] ma [15] = '{32'h0003FFFC, 32'h00040000, 32'h003C0004, 32'h00400000,
      32'h00BFFFFC, 32'h00C00000, 32'h01000000, 32'h01200000, 32'h013FFFFC, 32'h01400000,
      32'h01C00000, 32'h02000000, 32'hFFFF8000, 32'hFFFFC000, 32'hFFFFE000};
   int ms [15] = '{-1, -1, 0, 1, 2, 3, -1, 4, 4, 5, 7, -1, -1, -1, -1};
   region_t mr [15] = '{REG_ROM, REG_RSVD, REG_EXT, REG_EXT, REG_EXT, REG_EXT, REG_RSVD,
      REG_EXT, REG_EXT, REG_EXT, REG_EXT, REG_RSVD, REG_PERI, REG_RSVD, REG_RAM};
   logic [3:0] lp [6] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'hF, 4'h3};

   external_bus_address_decoder #(.WAIT_MAX(15)) u_external_bus_address_decoder (
      .sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .straps(straps), .req(req),
      .req_valid(req_valid), .acc_done(acc_done), .acc_error(acc_error),
      .acc_region(acc_region), .acc_width(acc_width), .ctrl_we(ctrl_we),
      .ctrl_idx(ctrl_idx), .ctrl_wdata(ctrl_wdata), .ctrl_rdata(ctrl_rdata),
      .addr_hi_enable(addr_hi_enable), .ext_addr(ext_addr), .ext_addr_hi_oe(hi_oe),
      .space_select_n(sel_n), .read_strobe_n(read_strobe_n), .write_lane3_n(w3),
      .write_lane2_n(w2), .write_lane1_n(w1), .write_lane0_n(w0),
      .wait_req_n(wait_req_n), .ext_master_request_n(ext_master_request_n),
      .bus_grant_n(bus_grant_n));

   sram_partner u_sram_partner (
      .sys_clk(sys_clk), .space_select_n(sel_n), .stretch(stretch),
      .wait_req_n(wait_req_n));

   // Free-running system clock
   always #5 sys_clk = ~sys_clk;

   task automatic summarize;
      $display("Mismatches %0d of %0d compares", bad_count, cmp_count);
      if (cmp_count > 0 && bad_count == 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   task automatic do_reset;
      resetn = 1'b0;
      repeat (10) @(negedge sys_clk);
      resetn = 1'b1;
      bc = BUS1_RST;
      @(negedge sys_clk);
   endtask : do_reset

   task automatic wr_ctrl(input logic [2:0] idx, input logic [15:0] d);
      ctrl_idx = idx;
      ctrl_wdata = d;
      ctrl_we = 1'b1;
      @(negedge sys_clk);
      ctrl_we = 1'b0;
      @(negedge sys_clk);
      if (idx == 3'(IDX_BUS1)) begin
         bc = d;
      end
   endtask : wr_ctrl

   task automatic rd_ctrl(input logic [2:0] idx, input logic [15:0] e, input string n);
      ctrl_idx = idx;
      @(negedge sys_clk);
      `CHK(n, e, ctrl_rdata)
   endtask : rd_ctrl

   // Width a space should report, from straps and our copy of bus_ctrl_one
   function automatic logic [1:0] exp_w(input int s);
      if (!straps.rom_enabled && s % 4 == 0) begin
         return straps.large_pkg ? (straps.mode_wide ? WIDTH_32 : WIDTH_16)
                                 : (straps.mode_wide ? WIDTH_16 : WIDTH_8);
      end
      if (bc[LG_POS + s % 4]) begin
         return WIDTH_32;
      end
      return bc[SZ_POS + s % 4] ? WIDTH_16 : WIDTH_8;
   endfunction : exp_w

   // One access held until done; strobes are recorded on every cycle of it, select, address and hi_oe only while a select is low
   task automatic access(input logic [31:0] a, input logic wr, input logic [3:0] ln,
                         input region_t er, input int s, output int cyc);
      logic [7:0] sel_seen;
      logic [21:0] adr_seen;
      logic [3:0] ln_seen;
      logic [3:0] oe_seen;
      logic rd_seen;
      sel_seen = 8'hFF;
      adr_seen = '0;
      ln_seen = 4'h0;
      oe_seen = 4'h0;
      rd_seen = 1'b0;
      cyc = 0;
      req = '{a, wr, ln};
      req_valid = 1'b1;
      do begin
         @(negedge sys_clk);
         cyc++;
         if (sel_n != 8'hFF) begin
            sel_seen = sel_n;
            adr_seen = ext_addr;
            oe_seen = hi_oe;
         end
         rd_seen |= !read_strobe_n;
         ln_seen |= ~{w3, w2, w1, w0};
      end while (acc_done !== 1'b1 && cyc < 80);
      req_valid = 1'b0;
      `CHK("acc_done", 1'b1, acc_done)
      `CHK("region", 3'(er), acc_region)
      `CHK("error", er == REG_RSVD, acc_error)
      `CHK("select", (s < 0) ? 8'hFF : ~(8'h01 << s), sel_seen)
      `CHK("read strobe", (s >= 0) && !wr, rd_seen)
      `CHK("lanes", (s >= 0 && wr) ? ln : 4'h0, ln_seen)
      if (s >= 0) begin
         `CHK("addr", {addr_hi_enable ? a[21:18] : 4'h0, a[17:0]}, adr_seen)
         `CHK("hi_oe", {4{addr_hi_enable}}, oe_seen)
         `CHK("width", exp_w(s), acc_width)
      end else if (er == REG_ROM || er == REG_RAM) begin
         `CHK("width", WIDTH_32, acc_width)
      end
      @(negedge sys_clk);
   endtask : access

   // Hang guard, far beyond the few hundred cycles the tests need
   initial begin
      #200000;
      bad_count++;
      $display("Error watchdog expected finish seen hang");
      summarize();
   end

   initial begin
      do_reset();
      `CHK("grant idle", 1'b1, bus_grant_n)
      `CHK("select idle", 8'hFF, sel_n)
      `CHK("hi_oe reset", 4'h0, hi_oe)
      rd_ctrl(3'(IDX_BUS1), BUS1_RST, "bus1");
      rd_ctrl(3'(IDX_BUS2), BUS2_RST, "bus2");
      rd_ctrl(3'(IDX_WAIT1), WAIT1_RST, "wait1");
      rd_ctrl(3'(IDX_WAIT2), WAIT2_RST, "wait2");
      rd_ctrl(3'(IDX_RAMEMU), RAMEMU_RST, "ramemu");
      wr_ctrl(3'h5, 16'hFFFF);
      rd_ctrl(3'h5, 16'h0000, "idx5");
      wr_ctrl(3'(IDX_WAIT1), 16'h0000);
      wr_ctrl(3'(IDX_WAIT2), 16'h0000);
      rd_ctrl(3'(IDX_WAIT1), 16'h0000, "wait1 wr");
      // Clock enable low must drop a control write
      clk_en = 1'b0;
      wr_ctrl(3'(IDX_BUS2), 16'h1234);
      clk_en = 1'b1;
      rd_ctrl(3'(IDX_BUS2), BUS2_RST, "bus2 frozen");
      // Map walk with top address pins still in port mode
      for (int i = 0; i < 15; i++) begin
         access(ma[i], 1'b0, 4'h0, mr[i], ms[i], c1);
      end
      addr_hi_enable = 1'b1;
      // Enable is registered; give it one edge before the next access
      @(negedge sys_clk);
      access(32'h003C0004, 1'b0, 4'h0, REG_EXT, 0, c1);
      for (int i = 0; i < 6; i++) begin
         access(32'h00400010, 1'b1, lp[i], REG_EXT, 1, c1);
      end
      // Space pair 1 to longword, pair 2 to byte
      wr_ctrl(3'(IDX_BUS1), 16'h602B);
      access(32'h00400000, 1'b0, 4'h0, REG_EXT, 1, c1);
      access(32'h01400000, 1'b0, 4'h0, REG_EXT, 5, c1);
      access(32'h01800000, 1'b1, 4'h3, REG_EXT, 6, c1);
      // Only space 2 and 6 get three waits
      wr_ctrl(3'(IDX_WAIT1), 16'h0300);
      wr_ctrl(3'(IDX_WAIT2), 16'h0300);
      access(32'h00400000, 1'b0, 4'h0, REG_EXT, 1, c1);
      access(32'h00800000, 1'b0, 4'h0, REG_EXT, 2, c2);
      `CHK("wait space2", 3, c2 - c1)
      access(32'h01800000, 1'b0, 4'h0, REG_EXT, 6, c2);
      `CHK("wait space6", 3, c2 - c1)
      // Wait pin stretches a slow space
      wr_ctrl(3'(IDX_WAIT1), 16'h8000);
      access(32'h00C00000, 1'b0, 4'h0, REG_EXT, 3, c1);
      stretch = 8'd12;
      access(32'h00C00000, 1'b0, 4'h0, REG_EXT, 3, c2);
      stretch = 8'd0;
      `CHK("stretched", 1'b1, c2 > c1)
      // External master takes the bus; our request must wait
      ext_master_request_n = 1'b0;
      c1 = 0;
      while (bus_grant_n !== 1'b0 && c1 < 20) begin
         @(negedge sys_clk);
         c1++;
      end
      `CHK("grant", 1'b0, bus_grant_n)
      req = '{32'h00400000, 1'b0, 4'h0};
      req_valid = 1'b1;
      c2 = 0;
      repeat (8) begin
         @(negedge sys_clk);
         c2 += int'(sel_n !== 8'hFF || acc_done !== 1'b0);
      end
      `CHK("held off", 0, c2)
      ext_master_request_n = 1'b1;
      access(32'h00400000, 1'b0, 4'h0, REG_EXT, 1, c1);
      `CHK("grant off", 1'b1, bus_grant_n)
      // ROM-less map under each package and mode pin
      for (int k = 0; k < 4; k++) begin
         straps = '{1'b0, k[1], k[0], 1'b1};
         do_reset();
         access(32'h00000000, 1'b0, 4'h0, REG_EXT, 0, c1);
         access(32'h003FFFFC, 1'b0, 4'h0, REG_EXT, 0, c1);
         access(32'h01000000, 1'b0, 4'h0, REG_EXT, 4, c1);
         access(32'h013FFFFC, 1'b0, 4'h0, REG_EXT, 4, c1);
      end
      // Variant without upper spaces
      straps = '{1'b1, 1'b1, 1'b1, 1'b0};
      do_reset();
      access(32'h01200000, 1'b0, 4'h0, REG_RSVD, -1, c1);
      access(32'h01C00000, 1'b1, 4'hF, REG_RSVD, -1, c1);
      summarize();
   end
endmodule : external_bus_address_decoder_tb
